//--- cpu_trap_wait_test_decode.sv
`timescale 1ns/100ps
`include "cpu_trap_wait_test_regs.svh"
module cpu_trap_wait_test_decode
  import cpu_trap_wait_test_pkg::*;
(
  input  wire logic        clk,          // 125 MHz core clock
  input  wire logic        reset_n,      // Synchronous reset, active low
  input  wire logic        ce,           // Clock enable, freezes all state
  input  wire logic        irq_req,      // Interrupt request, wakes from wait
  input  wire logic [7:0]  mem_rdata,    // Read data for current mem_addr
  output logic [15:0]      mem_addr,     // Bus address
  output logic             mem_rd,       // Read strobe
  output logic             mem_wr,       // Write strobe
  output logic [7:0]       mem_wdata,    // Write data
  output logic             clock_run,    // Low while processing is halted
  output logic             bad_opcode,   // Pulse on an opcode not handled here
  output logic [7:0]       flags_out,    // Condition flags
  output logic [7:0]       acc_out,      // Accumulator
  output logic [15:0]      index_out,    // Index pair
  output logic [15:0]      stack_out     // Stack pointer
);

  // ========================================================================
  // Helpers
  function automatic logic [15:0] join16(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  function automatic logic [15:0] add_offset8(input logic [15:0] base, input logic [7:0] off);
    return base + {8'h00, off};
  endfunction

  function automatic logic [7:0] set_nz(input logic [7:0] f, input logic n, input logic z);
    logic [7:0] r;
    r = f;
    r[`FLAG_OVERFLOW] = 1'b0;
    r[`FLAG_NEGATIVE] = n;
    r[`FLAG_ZERO]     = z;
    return r;
  endfunction

  core_state_type r_reg;
  core_state_type r_next;
  logic [7:0]     cur_op;
  logic [7:0]     test_operand;
  logic           test_neg;
  logic           test_zero;

  // ========================================================================
  // Opcode byte arrives on the bus in step zero, held afterwards
  assign cur_op = (r_reg.step == 4'h0) ? mem_rdata : r_reg.op;

  // Inherent test forms look at a register, the rest at the bus byte
  always_comb begin
    test_operand = mem_rdata;
    if (!r_reg.prefix && r_reg.step == 4'h0) begin
      if (cur_op == `OP_TEST_ACCUM) test_operand = r_reg.acc;
      if (cur_op == `OP_TEST_INDEX) test_operand = r_reg.hx[7:0];
    end
  end

  test_flag_unit u_test_flags (
    .operand  (test_operand),
    .negative (test_neg),
    .zero     (test_zero)
  );

  // ========================================================================
  // Sequencer
  always_comb begin
    r_next        = r_reg;
    r_next.mem.rd = 1'b0;
    r_next.mem.wr = 1'b0;
    r_next.bad_op = 1'b0;
    if (r_reg.state == ST_EXEC && r_reg.step == 4'h0) begin
      r_next.op = mem_rdata;
    end

    unique case (r_reg.state)
      ST_FETCH: begin
        r_next.mem.addr = r_reg.pc;
        r_next.mem.rd   = 1'b1;
        r_next.pc       = r_reg.pc + 16'h0001;
        r_next.step     = 4'h0;
        r_next.prefix   = 1'b0;
        r_next.state    = ST_EXEC;
      end

      ST_HALT: begin
        // Woken by any request; vectoring is left to the interrupt logic
        if (irq_req) begin
          r_next.clock_run = 1'b1;
          r_next.state     = ST_FETCH;
        end
      end

      ST_EXEC: begin
        r_next.step = r_reg.step + 4'h1;
        if (r_reg.prefix) begin
          if (cur_op == `OP_TEST_STACK8) begin
            unique case (r_reg.step)
              4'h0: begin
                r_next.mem.addr = r_reg.pc;
                r_next.mem.rd   = 1'b1;
                r_next.pc       = r_reg.pc + 16'h0001;
              end
              4'h1: begin
                r_next.mem.addr = add_offset8(r_reg.sp, mem_rdata);
                r_next.mem.rd   = 1'b1;
              end
              default: begin
                r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
              end
            endcase
          end else begin
            r_next.bad_op = 1'b1;
          end
        end else begin
          unique case (cur_op)
            `OP_STACK_PREFIX: begin
              // Second opcode byte fetched before any offset byte
              r_next.mem.addr = r_reg.pc;
              r_next.mem.rd   = 1'b1;
              r_next.pc       = r_reg.pc + 16'h0001;
              r_next.prefix   = 1'b1;
              r_next.step     = 4'h0;
            end

            `OP_SOFTWARE_TRAP: begin
              r_next.mem.addr  = r_reg.sp;
              r_next.sp        = r_reg.sp - 16'h0001;
              r_next.mem.wr    = (r_reg.step <= 4'h4);
              unique case (r_reg.step)
                4'h0: r_next.mem.wdata = r_reg.pc[7:0];
                4'h1: r_next.mem.wdata = r_reg.pc[15:8];
                4'h2: r_next.mem.wdata = r_reg.hx[7:0];
                4'h3: r_next.mem.wdata = r_reg.acc;
                4'h4: r_next.mem.wdata = r_reg.flags;
                default: begin
                  r_next.sp = r_reg.sp;
                end
              endcase
              if (r_reg.step == 4'h4) begin
                r_next.flags[`FLAG_INT_MASK] = 1'b1;
              end
              if (r_reg.step == 4'h5) begin
                r_next.mem.addr = `TRAP_VECTOR_HIGH;
                r_next.mem.rd   = 1'b1;
              end
              if (r_reg.step == 4'h6) begin
                r_next.tmp_hi   = mem_rdata;
                r_next.mem.addr = `TRAP_VECTOR_LOW;
                r_next.mem.rd   = 1'b1;
              end
              if (r_reg.step == 4'h7) begin
                r_next.pc = join16(r_reg.tmp_hi, mem_rdata);
              end
            end

            `OP_WAIT_INTERRUPT: begin
              // Only the mask changes; other flags untouched
              r_next.flags[`FLAG_INT_MASK] = 1'b0;
              r_next.clock_run             = 1'b0;
              r_next.state                 = ST_HALT;
            end

            `OP_TEST_ACCUM, `OP_TEST_INDEX: begin
              r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
            end

            `OP_TEST_DIRECT: begin
              if (r_reg.step == 4'h0) begin
                r_next.mem.addr = r_reg.pc;
                r_next.mem.rd   = 1'b1;
                r_next.pc       = r_reg.pc + 16'h0001;
              end else if (r_reg.step == 4'h1) begin
                r_next.mem.addr = join16(8'h00, mem_rdata);
                r_next.mem.rd   = 1'b1;
              end else begin
                r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
              end
            end

            `OP_TEST_INDEXED8: begin
              if (r_reg.step == 4'h0) begin
                r_next.mem.addr = r_reg.pc;
                r_next.mem.rd   = 1'b1;
                r_next.pc       = r_reg.pc + 16'h0001;
              end else if (r_reg.step == 4'h1) begin
                r_next.mem.addr = add_offset8(r_reg.hx, mem_rdata);
                r_next.mem.rd   = 1'b1;
              end else begin
                r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
              end
            end

            `OP_TEST_INDEXED: begin
              if (r_reg.step == 4'h0) begin
                r_next.mem.addr = r_reg.hx;
                r_next.mem.rd   = 1'b1;
              end else begin
                r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
              end
            end

            `OP_STACK_TO_INDEX: begin
              if (r_reg.step == 4'h0) r_next.hx = r_reg.sp + 16'h0001;
            end

            `OP_INDEX_TO_STACK: begin
              if (r_reg.step == 4'h0) r_next.sp = r_reg.hx - 16'h0001;
            end

            `OP_LOAD_EXTENDED, `OP_LOAD_INDEXED16: begin
              // Two address bytes follow the opcode, high one first
              if (r_reg.step <= 4'h1) begin
                r_next.mem.addr = r_reg.pc;
                r_next.mem.rd   = 1'b1;
                r_next.pc       = r_reg.pc + 16'h0001;
              end
              if (r_reg.step == 4'h1) r_next.tmp_hi = mem_rdata;
              if (r_reg.step == 4'h2) begin
                r_next.mem.rd = 1'b1;
                if (cur_op == `OP_LOAD_EXTENDED) begin
                  r_next.mem.addr = join16(r_reg.tmp_hi, mem_rdata);
                end else begin
                  r_next.mem.addr = r_reg.hx + join16(r_reg.tmp_hi, mem_rdata);
                end
              end
              if (r_reg.step == 4'h3) begin
                r_next.acc   = mem_rdata;
                r_next.flags = set_nz(r_reg.flags, test_neg, test_zero);
              end
            end

            `OP_MOVE_IX_TO_DIRECT: begin
              unique case (r_reg.step)
                4'h0: begin
                  r_next.mem.addr = r_reg.hx;
                  r_next.mem.rd   = 1'b1;
                  r_next.hx       = r_reg.hx + 16'h0001;
                end
                4'h1: begin
                  r_next.tmp_data = mem_rdata;
                  r_next.flags    = set_nz(r_reg.flags, test_neg, test_zero);
                  r_next.mem.addr = r_reg.pc;
                  r_next.mem.rd   = 1'b1;
                  r_next.pc       = r_reg.pc + 16'h0001;
                end
                4'h2: begin
                  r_next.mem.addr  = join16(8'h00, mem_rdata);
                  r_next.mem.wr    = 1'b1;
                  r_next.mem.wdata = r_reg.tmp_data;
                end
                default: begin
                end
              endcase
            end

            `OP_MOVE_DIRECT_TO_IX: begin
              unique case (r_reg.step)
                4'h0: begin
                  r_next.mem.addr = r_reg.pc;
                  r_next.mem.rd   = 1'b1;
                  r_next.pc       = r_reg.pc + 16'h0001;
                end
                4'h1: begin
                  r_next.mem.addr = join16(8'h00, mem_rdata);
                  r_next.mem.rd   = 1'b1;
                end
                4'h2: begin
                  r_next.mem.addr  = r_reg.hx;
                  r_next.mem.wr    = 1'b1;
                  r_next.mem.wdata = mem_rdata;
                  r_next.flags     = set_nz(r_reg.flags, test_neg, test_zero);
                end
                default: begin
                  r_next.hx = r_reg.hx + 16'h0001;
                end
              endcase
            end

            default: begin
              // Not ours: skipped as a one-cycle no-op and reported
              r_next.bad_op = 1'b1;
            end
          endcase
        end

        // Final step overlaps the fetch of the next opcode
        if (r_next.state == ST_EXEC && r_next.step == 4'h0 && !r_next.prefix) begin
          r_next.step = 4'h0;
        end
        if (r_reg.state == ST_EXEC && r_next.state == ST_EXEC && last_step(r_reg, cur_op)) begin
          r_next.mem.addr = r_next.pc;
          r_next.mem.rd   = 1'b1;
          r_next.mem.wr   = 1'b0;
          r_next.pc       = r_next.pc + 16'h0001;
          r_next.step     = 4'h0;
          r_next.prefix   = 1'b0;
        end
      end

      default: begin
        r_next.state = ST_FETCH;
      end
    endcase
  end

  // ========================================================================
  // Instruction end detection; the prefix byte itself never ends one
  function automatic logic last_step(input core_state_type s, input logic [7:0] op);
    logic done;
    done = 1'b1;
    if (s.prefix) begin
      if (op == `OP_TEST_STACK8) done = (s.step == `LAST_STEP_TEST_SP8);
    end else begin
      unique case (op)
        `OP_STACK_PREFIX:      done = 1'b0;
        `OP_SOFTWARE_TRAP:     done = (s.step == `LAST_STEP_TRAP);
        `OP_TEST_DIRECT:       done = (s.step == `LAST_STEP_TEST_DIRECT);
        `OP_TEST_INDEXED8:     done = (s.step == `LAST_STEP_TEST_IX8);
        `OP_TEST_INDEXED:      done = (s.step == `LAST_STEP_TEST_IX);
        `OP_STACK_TO_INDEX,
        `OP_INDEX_TO_STACK:    done = (s.step == `LAST_STEP_TRANSFER);
        `OP_LOAD_EXTENDED,
        `OP_LOAD_INDEXED16:    done = (s.step == `LAST_STEP_LOAD);
        `OP_MOVE_IX_TO_DIRECT,
        `OP_MOVE_DIRECT_TO_IX: done = (s.step == `LAST_STEP_MOVE);
        default:               done = 1'b1;
      endcase
    end
    return done;
  endfunction

  // ========================================================================
  // State register; ce low holds everything, including the bus strobes
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_reg.state     <= ST_FETCH;
      r_reg.step      <= 4'h0;
      r_reg.prefix    <= 1'b0;
      r_reg.op        <= 8'h00;
      r_reg.pc        <= `PC_RESET;
      r_reg.sp        <= `STACK_RESET;
      r_reg.hx        <= `INDEX_RESET;
      r_reg.acc       <= `ACCUM_RESET;
      r_reg.flags     <= `FLAGS_RESET;
      r_reg.tmp_hi    <= 8'h00;
      r_reg.tmp_data  <= 8'h00;
      r_reg.mem       <= '0;
      r_reg.clock_run <= 1'b1;
      r_reg.bad_op    <= 1'b0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ========================================================================
  // Outputs, all straight from the state register
  assign mem_addr   = r_reg.mem.addr;
  assign mem_rd     = r_reg.mem.rd;
  assign mem_wr     = r_reg.mem.wr;
  assign mem_wdata  = r_reg.mem.wdata;
  assign clock_run  = r_reg.clock_run;
  assign bad_opcode = r_reg.bad_op;
  assign flags_out  = r_reg.flags;
  assign acc_out    = r_reg.acc;
  assign index_out  = r_reg.hx;
  assign stack_out  = r_reg.sp;

endmodule // cpu_trap_wait_test_decode

//--- cpu_trap_wait_test_pkg.sv
package cpu_trap_wait_test_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_FETCH = 3'b001,
    ST_EXEC  = 3'b010,
    ST_HALT  = 3'b100
  } seq_state_type;

  // ========================================================================
  // Internal bus request
  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } mem_req_type;

  // ========================================================================
  // Whole core state
  typedef struct packed {
    seq_state_type state;
    logic [3:0]    step;
    logic          prefix;
    logic [7:0]    op;
    logic [15:0]   pc;
    logic [15:0]   sp;
    logic [15:0]   hx;
    logic [7:0]    acc;
    logic [7:0]    flags;
    logic [7:0]    tmp_hi;
    logic [7:0]    tmp_data;
    mem_req_type   mem;
    logic          clock_run;
    logic          bad_op;
  } core_state_type;

endpackage

//--- cpu_trap_wait_test_regs.svh
`ifndef CPU_TRAP_WAIT_TEST_REGS_SVH
`define CPU_TRAP_WAIT_TEST_REGS_SVH

// ==========================================================================
// Opcodes handled by this core fragment
`define OP_SOFTWARE_TRAP       8'h83
`define OP_WAIT_INTERRUPT      8'h8F
`define OP_TEST_DIRECT         8'h3D
`define OP_TEST_ACCUM          8'h4D
`define OP_TEST_INDEX          8'h5D
`define OP_TEST_INDEXED8       8'h6D
`define OP_TEST_INDEXED        8'h7D
`define OP_STACK_PREFIX        8'h9E
`define OP_TEST_STACK8         8'h6D
`define OP_STACK_TO_INDEX      8'h95
`define OP_INDEX_TO_STACK      8'h94
`define OP_LOAD_EXTENDED       8'hC6
`define OP_LOAD_INDEXED16      8'hD6
`define OP_MOVE_DIRECT_TO_IX   8'h5E
`define OP_MOVE_IX_TO_DIRECT   8'h7E

// ==========================================================================
// Condition flag bit positions
`define FLAG_OVERFLOW          7
`define FLAG_HALF_CARRY        4
`define FLAG_INT_MASK          3
`define FLAG_NEGATIVE          2
`define FLAG_ZERO              1
`define FLAG_CARRY             0

// ==========================================================================
// Reset values and vector locations
`define FLAGS_RESET            8'h68
`define STACK_RESET            16'h00FF
`define INDEX_RESET            16'h0000
`define ACCUM_RESET            8'h00
`define PC_RESET               16'hF000
`define TRAP_VECTOR_HIGH       16'hFFFC
`define TRAP_VECTOR_LOW        16'hFFFD

// ==========================================================================
// Last sequencer step of each multi-cycle instruction (cycles minus one, minus two for the prefixed stack test)
`define LAST_STEP_TRAP         4'h8
`define LAST_STEP_TEST_DIRECT  4'h2
`define LAST_STEP_TEST_IX8     4'h2
`define LAST_STEP_TEST_IX      4'h1
`define LAST_STEP_TEST_SP8     4'h2
`define LAST_STEP_TRANSFER     4'h1
`define LAST_STEP_LOAD         4'h3
`define LAST_STEP_MOVE         4'h3

`endif

//--- decode_rules_monitor.sv
`timescale 1ns/100ps
// ==========================================================================
// Bus-level checks on trap, wait and test sequencing
module decode_rules_monitor (
  input wire logic        clk,        // Core clock
  input wire logic        reset_n,    // Synchronous reset, active low
  input wire logic        ce,         // Clock enable
  input wire logic        irq_req,    // Wake request
  input wire logic [15:0] mem_addr,   // Bus address
  input wire logic        mem_rd,     // Read strobe
  input wire logic        mem_wr,     // Write strobe
  input wire logic        clock_run,  // Low while halted
  input wire logic [7:0]  flags_out   // Condition flags
);
  // Ticks only on enabled edges, so a frozen cycle never looks like a repeat
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (!reset_n);

  // Remaining four stacking writes, then both vector reads
  sequence trap_pushes;
    mem_wr [*4];
  endsequence
  sequence vector_reads;
    (mem_rd && mem_addr == 16'hFFFC) ##1 (mem_rd && mem_addr == 16'hFFFD);
  endsequence

  a_trap_push_burst: assert property (
    $rose(mem_wr) ##1 mem_wr |-> trap_pushes ##1 vector_reads)
    else $error("trap stacking not followed by vector reads");
  a_trap_push_addr: assert property (
    mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h0001)
    else $error("stacking address did not step down by one");
  a_trap_vector_end: assert property (
    mem_rd && mem_addr == 16'hFFFD |-> flags_out[3] ##1 !mem_rd ##1 mem_rd)
    else $error("trap did not mask and fetch two cycles after vector");
  a_wait_mask_clear: assert property (
    $fell(clock_run) |-> !flags_out[3] && flags_out[7:4] == $past(flags_out[7:4])
      && flags_out[2:0] == $past(flags_out[2:0]))
    else $error("wait changed flags other than the mask");
  a_wait_bus_quiet: assert property (
    !clock_run |-> !mem_rd && !mem_wr)
    else $error("bus active while halted");
  a_wake_fetch: assert property (
    irq_req && !clock_run |=> clock_run ##1 mem_rd)
    else $error("wake did not resume fetch on time");
  a_test_flags_kept: assert property (
    $changed(flags_out[2:1]) |-> !flags_out[7] && $stable(flags_out[4])
      && $stable(flags_out[3]) && $stable(flags_out[0]))
    else $error("sign or zero update disturbed other flags");
  a_bus_one_strobe: assert property (!(mem_rd && mem_wr))
    else $error("read and write strobes together");
endmodule // decode_rules_monitor

bind cpu_trap_wait_test_decode decode_rules_monitor decode_rules_monitor_i (
  .clk(clk), .reset_n(reset_n), .ce(ce), .irq_req(irq_req), .mem_addr(mem_addr),
  .mem_rd(mem_rd), .mem_wr(mem_wr), .clock_run(clock_run), .flags_out(flags_out));

//--- program_memory_model.sv
`timescale 1ns/100ps
// ==========================================================================
// Program and data memory on the core bus, no wait states
module program_memory_model (
  input  wire logic        clk,        // Core clock
  input  wire logic [15:0] mem_addr,   // Bus address
  input  wire logic        mem_rd,     // Read strobe
  input  wire logic        mem_wr,     // Write strobe
  input  wire logic [7:0]  mem_wdata,  // Write data
  output logic      [7:0]  mem_rdata   // Read data
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_reg = 8'hA5;

  // Idle bus toggles every cycle so stale data never passes for a read
  // Plain always: the bench also loads this array directly
  always @(posedge clk) begin
    junk_reg <= ~junk_reg;
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end

  // Answer in the same cycle, as the core samples at the next edge
  assign mem_rdata = mem_rd ? mem[mem_addr] : junk_reg;
endmodule // program_memory_model

//--- tb.sv
`timescale 1ns/100ps
// ==========================================================================
// Instruction-level model compared with the core after every instruction
module tb;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        ce = 1'b1;
  logic        ce_mix = 1'b0;   // Random enable gaps when set
  logic        irq_req = 1'b0;
  int          m_bad = 0;       // Expected unsupported-opcode flag
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic        mem_rd;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic        clock_run;
  logic        bad_opcode;
  logic [7:0]  flags_out;
  logic [7:0]  acc_out;
  logic [15:0] index_out;
  logic [15:0] stack_out;
  int          n_fail = 0;
  int          tests_run = 0;
  int          m_pc;
  int          m_a;
  int          m_hx;
  int          m_sp;
  int          m_f;
  int          v;
  int          d;
  int          e;
  int          stk[$];          // Expected stacked bytes, first push first

  cpu_trap_wait_test_decode cpu_trap_wait_test_decode_i (
    .clk(clk), .reset_n(reset_n), .ce(ce), .irq_req(irq_req), .mem_rdata(mem_rdata),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .clock_run(clock_run), .bad_opcode(bad_opcode), .flags_out(flags_out),
    .acc_out(acc_out), .index_out(index_out), .stack_out(stack_out));
  program_memory_model program_memory_model_i (
    .clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  // Clock, and an enable that drops about one cycle in four when mixed
  always #4 clk = ~clk;
  always @(posedge clk) begin
    ce <= ce_mix ? ($urandom_range(3) != 0) : 1'b1;
  end

  // ==========================================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic poke(input int a, input int b);
    program_memory_model_i.mem[a[15:0]] = b[7:0];
  endtask
  // Sign and zero from the byte, overflow cleared, the rest kept
  function automatic int nz(input int x);
    return (m_f & 8'h79) | ((x & 8'h80) ? 4 : 0) | (((x & 8'hFF) == 0) ? 2 : 0);
  endfunction
  task automatic cmp_state();
    check(flags_out, m_f[7:0]);
    check(bad_opcode, m_bad[15:0]);
    check(acc_out, m_a[7:0]);
    check(index_out, m_hx[15:0]);
    check(stack_out, m_sp[15:0]);
  endtask
  task automatic wait_fetch();
    for (int i = 0; i < 40 && !(mem_rd === 1'b1 && mem_addr === m_pc[15:0]); i++) begin
      @(negedge clk);
    end
    check(mem_addr, m_pc[15:0]);
  endtask
  // Enabled cycles are counted from this fetch up to the next one
  task automatic run_op(input int b0, input int b1, input int b2, input int cyc,
                        input int nxt);
    int n;
    n = 0;
    poke(m_pc, b0);
    poke(m_pc + 1, b1);
    poke(m_pc + 2, b2);
    do begin
      n += int'(ce);
      @(negedge clk);
    end while (!(mem_rd === 1'b1 && mem_addr === nxt[15:0]) && n < 40);
    check(n, cyc);
    m_pc = nxt;
    cmp_state();
  endtask
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard, well beyond the hundred-odd cycles the sequence needs
  initial begin
    #40000;
    n_fail++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    v = $urandom(53532);
    m_pc = 16'hF000;
    m_a = 0;
    m_hx = 0;
    m_sp = 16'h00FF;
    m_f = 8'h68;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    wait_fetch();
    cmp_state();
    ce_mix = 1'b1;
    m_hx = m_sp + 1;
    run_op(8'h95, 0, 0, 2, m_pc + 1);
    m_f = nz(m_hx);
    run_op(8'h5D, 0, 0, 1, m_pc + 1);
    // Loads, alternating plain and index-offset addresses
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 8'h80 : $urandom_range(255);
      d = $urandom_range(16'h3FFF, 16'h0200);
      m_a = v;
      m_f = nz(v);
      poke(d + ((i % 2) ? m_hx : 0), v);
      run_op((i % 2) ? 8'hD6 : 8'hC6, d >> 8, d & 8'hFF, 4, m_pc + 3);
      run_op(8'h4D, 0, 0, 1, m_pc + 1);
    end
    // Memory forms of the test, each twice
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 0 : (i == 1) ? 8'h80 : $urandom_range(255);
      d = $urandom_range(8'h7F, 8'h10);
      m_f = nz(v);
      case (i % 4)
        0: begin
          poke(d, v);
          run_op(8'h3D, d, 0, 3, m_pc + 2);
        end
        1: begin
          poke(m_hx + d, v);
          run_op(8'h6D, d, 0, 3, m_pc + 2);
        end
        2: begin
          poke(m_hx, v);
          run_op(8'h7D, 0, 0, 2, m_pc + 1);
        end
        default: begin
          poke(m_sp + d, v);
          run_op(8'h9E, 8'h6D, d, 4, m_pc + 3);
        end
      endcase
    end
    // Moves through the index pair, which steps after each transfer
    v = $urandom_range(255);
    d = $urandom_range(8'h7F, 8'h10);
    poke(m_hx, v);
    m_hx++;
    m_f = nz(v);
    run_op(8'h7E, d, 0, 4, m_pc + 2);
    check(program_memory_model_i.mem[d], v[7:0]);
    v = $urandom_range(255);
    poke(d, v);
    e = m_hx;
    m_hx++;
    m_f = nz(v);
    run_op(8'h5E, d, 0, 4, m_pc + 2);
    check(program_memory_model_i.mem[e], v[7:0]);
    m_f = nz(m_a);
    run_op(8'h4D, 0, 0, 1, m_pc + 1);
    m_sp = m_hx - 1;
    run_op(8'h94, 0, 0, 2, m_pc + 1);
    ce_mix = 1'b0;
    // Wait: mask cleared, bus silent until a wake request
    poke(m_pc, 8'h8F);
    m_f = m_f & 8'hF7;
    for (int i = 0; i < 10 && clock_run !== 1'b0; i++) @(negedge clk);
    check(clock_run, 0);
    cmp_state();
    repeat (6) @(negedge clk) check(mem_rd | mem_wr, 0);
    @(posedge clk) irq_req <= 1'b1;
    @(posedge clk) irq_req <= 1'b0;
    m_pc = m_pc + 1;
    wait_fetch();
    // Trap: context stacked downward, mask set, vectored fetch
    poke(16'hFFFC, 8'hF8);
    poke(16'hFFFD, 8'h00);
    e = m_sp;
    stk = '{(m_pc + 1) & 8'hFF, (m_pc + 1) >> 8, m_hx & 8'hFF, m_a, m_f};
    m_sp = m_sp - 5;
    m_f = m_f | 8'h08;
    run_op(8'h83, 0, 0, 9, 16'hF800);
    foreach (stk[k]) check(program_memory_model_i.mem[e - k], stk[k][7:0]);
    m_bad = 1;
    run_op(8'h9D, 0, 0, 1, m_pc + 1);
    print_verdict();
  end
endmodule // tb

//--- test_flag_unit.sv
`timescale 1ns/100ps
// ==========================================================================
// Operand minus zero: sign and zero of the byte, nothing stored
module test_flag_unit
  import cpu_trap_wait_test_pkg::*;
(
  input  wire logic [7:0] operand,   // Byte under test
  output logic            negative,  // Bit 7 of result
  output logic            zero       // Result is zero
);

  logic [7:0] difference;

  // Subtracting zero keeps the operand; kept explicit for clarity
  always_comb begin
    difference = operand - 8'h00;
    negative   = difference[7];
    zero       = (difference == 8'h00);
  end

endmodule // test_flag_unit
